// ### verilog/sfic_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfic_regs.svh"

module sfic_top #(
  parameter int DEPTH       = 32,
  parameter int STAGE_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  // Register port behind the serial host link
  input  wire sfic_pkg::sfic_reg_req_t reg_req_i,
  output logic [7:0]                  reg_rdata_o,
  // Sample stream from the front ends
  input  wire sfic_pkg::sfic_sample_t sample_i,
  input  wire logic                   sample_valid_i,
  output logic                        sample_ready_o,
  // Front end events and modes
  input  wire logic                   supply_out_of_range_i,
  input  wire logic                   cardiac_done_i,
  input  wire logic                   proximity_mode_i,
  // Interrupt and slot status
  output logic                        irq_n_o,
  output logic [3:0]                  active_slots_o
);

  localparam int PW = $clog2(DEPTH);

  // Pointer registers are five bits wide, so only this depth fits
  if (DEPTH != 32 || STAGE_DEPTH < 2) begin : g_bad_param
    $error("sfic_top: DEPTH must be 32 and STAGE_DEPTH at least 2");
  end

  // ==========================================================
  // Functions
  function automatic logic reg_hit(input sfic_pkg::sfic_reg_req_t req, input logic [7:0] off, input logic wr);
    reg_hit = (wr ? req.wr : req.rd) && (req.addr == off);
  endfunction : reg_hit

  function automatic sfic_pkg::sfic_kind_t slot_kind(input logic [3:0] code);
    unique case (code)
      `SFIC_CODE_NONE:    slot_kind = sfic_pkg::SFIC_KIND_NONE;
      `SFIC_CODE_OPT1:    slot_kind = sfic_pkg::SFIC_KIND_OPT1;
      `SFIC_CODE_OPT2:    slot_kind = sfic_pkg::SFIC_KIND_OPT2;
      `SFIC_CODE_PILOT1:  slot_kind = sfic_pkg::SFIC_KIND_PILOT1;
      `SFIC_CODE_PILOT2:  slot_kind = sfic_pkg::SFIC_KIND_PILOT2;
      `SFIC_CODE_CARDIAC: slot_kind = sfic_pkg::SFIC_KIND_CARDIAC;
      default:            slot_kind = sfic_pkg::SFIC_KIND_RESERVED;
    endcase
  endfunction : slot_kind

  // ==========================================================
  // State
  sfic_pkg::sfic_sample_t mem [DEPTH];

  logic [PW-1:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic           full, next_full;
  logic [4:0]     lost, next_lost;
  logic [1:0]     elem_sel, next_elem_sel, part_sel, next_part_sel;
  logic           nearfull_irq_enable, next_nearfull_irq_enable;
  logic           supply_range_irq_enable, next_supply_range_irq_enable;
  logic           cardiac_ready_irq_enable, next_cardiac_ready_irq_enable;
  logic           nearfull_clear_on_data_read, next_nearfull_clear_on_data_read;
  logic           nearfull_assert_style, next_nearfull_assert_style;
  logic           overwrite_when_full, next_overwrite_when_full;
  logic [3:0]     nearfull_free_slots, next_nearfull_free_slots;
  logic [3:0][3:0] slot_type, next_slot_type;
  logic           sample_store_enable, next_sample_store_enable;
  logic           nearfull_flag, next_nearfull_flag;
  logic           supply_range_flag, next_supply_range_flag;
  logic           cardiac_ready_flag, next_cardiac_ready_flag;
  logic           cond_q, pushed_q;
  logic [7:0]     rdata, next_rdata;
  logic           irq_n, next_irq_n;
  logic [3:0]     active, next_active;

  // ==========================================================
  // Staging buffer between the front ends and sample storage
  sfic_pkg::sfic_sample_t stg_data;
  logic                   stg_valid;
  logic                   take;

  sfic_stage_fifo #(
    .WIDTH ($bits(sfic_pkg::sfic_sample_t)),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .in_data_i   (sample_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (stg_data),
    .out_valid_o (stg_valid),
    .out_ready_i (sample_store_enable)
  );

  // Disabled storage stalls the staging buffer so the source feels it
  assign take = stg_valid && sample_store_enable;

  // ==========================================================
  // Slot decode
  for (genvar s = 0; s < 4; s++) begin : g_slot
    sfic_pkg::sfic_kind_t kind;
    assign kind = slot_kind(slot_type[s]);
    assign next_active[s] = (kind != sfic_pkg::SFIC_KIND_NONE) &&
                            (kind != sfic_pkg::SFIC_KIND_RESERVED);
  end

  // ==========================================================
  // Datapath next state
  logic [PW:0] count;
  logic        empty, near_cond, data_rd, pop, roll, space, mem_we;
  logic [1:0]  last_elem;
  logic [2:0]  n_active;

  always_comb begin
    count     = full ? (PW+1)'(DEPTH) : {1'b0, wr_ptr - rd_ptr};
    empty     = !full && (wr_ptr == rd_ptr);
    near_cond = count >= ((PW+1)'(DEPTH) - {2'b00, nearfull_free_slots});
    n_active  = 3'(active[0]) + 3'(active[1]) + 3'(active[2]) + 3'(active[3]);
    // An all-empty slot map still reads one element per sample
    last_elem = (n_active == 3'd0) ? 2'd0 : 2'(n_active - 3'd1);
    data_rd   = reg_hit(reg_req_i, `SFIC_OFF_DATA, 1'b0);
    pop       = data_rd && !empty && (elem_sel == last_elem) && (part_sel == `SFIC_LAST_PART);
    roll      = overwrite_when_full || proximity_mode_i;
    space     = !full || pop;
    mem_we    = take && (space || roll);

    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_full     = full;
    next_lost     = lost;
    next_elem_sel = elem_sel;
    next_part_sel = part_sel;

    if (pop) begin
      next_rd_ptr   = rd_ptr + 1'b1;
      next_elem_sel = 2'd0;
      next_part_sel = 2'd0;
      next_full     = 1'b0;
    end else if (data_rd && !empty) begin
      if (part_sel == `SFIC_LAST_PART) begin
        next_part_sel = 2'd0;
        next_elem_sel = elem_sel + 2'd1;
      end else begin
        next_part_sel = part_sel + 2'd1;
      end
    end

    if (take) begin
      if (space) begin
        next_wr_ptr = wr_ptr + 1'b1;
        next_full   = (PW'(wr_ptr + 1'b1) == next_rd_ptr);
      end else begin
        if (lost != `SFIC_LOST_MAX) begin
          next_lost = lost + 5'd1;
        end
        if (roll) begin
          next_wr_ptr   = wr_ptr + 1'b1;
          next_rd_ptr   = rd_ptr + 1'b1;
          next_elem_sel = 2'd0;
          next_part_sel = 2'd0;
        end
      end
    end

    // Host pointer writes win over a push or pop in the same cycle
    if (reg_hit(reg_req_i, `SFIC_OFF_WRPTR, 1'b1)) begin
      next_wr_ptr = reg_req_i.wdata[PW-1:0];
      next_full   = 1'b0;
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_RDPTR, 1'b1)) begin
      next_rd_ptr   = reg_req_i.wdata[PW-1:0];
      next_elem_sel = 2'd0;
      next_part_sel = 2'd0;
      next_full     = 1'b0;
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_SYSCTL, 1'b1) &&
        reg_req_i.wdata[`SFIC_BIT_STORE_EN] && !sample_store_enable) begin
      next_wr_ptr   = `SFIC_RST_PTR;
      next_rd_ptr   = `SFIC_RST_PTR;
      next_full     = 1'b0;
      next_lost     = 5'd0;
      next_elem_sel = 2'd0;
      next_part_sel = 2'd0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr   <= `SFIC_RST_PTR;
      rd_ptr   <= `SFIC_RST_PTR;
      full     <= 1'b0;
      lost     <= 5'd0;
      elem_sel <= 2'd0;
      part_sel <= 2'd0;
      pushed_q <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      full     <= next_full;
      lost     <= next_lost;
      elem_sel <= next_elem_sel;
      part_sel <= next_part_sel;
      pushed_q <= mem_we;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (mem_we) begin
      mem[wr_ptr] <= stg_data;
    end
  end

  // ==========================================================
  // Configuration registers
  always_comb begin
    next_nearfull_irq_enable         = nearfull_irq_enable;
    next_supply_range_irq_enable     = supply_range_irq_enable;
    next_cardiac_ready_irq_enable    = cardiac_ready_irq_enable;
    next_nearfull_clear_on_data_read = nearfull_clear_on_data_read;
    next_nearfull_assert_style       = nearfull_assert_style;
    next_overwrite_when_full         = overwrite_when_full;
    next_nearfull_free_slots         = nearfull_free_slots;
    next_slot_type                   = slot_type;
    next_sample_store_enable         = sample_store_enable;
    if (reg_hit(reg_req_i, `SFIC_OFF_IRQEN1, 1'b1)) begin
      next_nearfull_irq_enable = reg_req_i.wdata[`SFIC_BIT_NEARFULL];
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_IRQEN2, 1'b1)) begin
      next_supply_range_irq_enable  = reg_req_i.wdata[`SFIC_BIT_SUPPLY];
      next_cardiac_ready_irq_enable = reg_req_i.wdata[`SFIC_BIT_CARDIAC];
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_CFG, 1'b1)) begin
      next_nearfull_clear_on_data_read = reg_req_i.wdata[`SFIC_BIT_CFG_CLR];
      next_nearfull_assert_style       = reg_req_i.wdata[`SFIC_BIT_CFG_STYLE];
      next_overwrite_when_full         = reg_req_i.wdata[`SFIC_BIT_CFG_ROLL];
      next_nearfull_free_slots         = reg_req_i.wdata[3:0];
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_SLOT12, 1'b1)) begin
      next_slot_type[0] = reg_req_i.wdata[3:0];
      next_slot_type[1] = reg_req_i.wdata[7:4];
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_SLOT34, 1'b1)) begin
      next_slot_type[2] = reg_req_i.wdata[3:0];
      next_slot_type[3] = reg_req_i.wdata[7:4];
    end
    if (reg_hit(reg_req_i, `SFIC_OFF_SYSCTL, 1'b1)) begin
      next_sample_store_enable = reg_req_i.wdata[`SFIC_BIT_STORE_EN];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nearfull_irq_enable         <= 1'b0;
      supply_range_irq_enable     <= 1'b0;
      cardiac_ready_irq_enable    <= 1'b0;
      nearfull_clear_on_data_read <= 1'b0;
      nearfull_assert_style       <= 1'b0;
      overwrite_when_full         <= 1'b0;
      nearfull_free_slots         <= `SFIC_RST_FREE;
      slot_type                   <= {4{`SFIC_RST_SLOT}};
      sample_store_enable         <= 1'b0;
    end else begin
      nearfull_irq_enable         <= next_nearfull_irq_enable;
      supply_range_irq_enable     <= next_supply_range_irq_enable;
      cardiac_ready_irq_enable    <= next_cardiac_ready_irq_enable;
      nearfull_clear_on_data_read <= next_nearfull_clear_on_data_read;
      nearfull_assert_style       <= next_nearfull_assert_style;
      overwrite_when_full         <= next_overwrite_when_full;
      nearfull_free_slots         <= next_nearfull_free_slots;
      slot_type                   <= next_slot_type;
      sample_store_enable         <= next_sample_store_enable;
    end
  end

  // ==========================================================
  // Flags, interrupt and read data
  logic st1_rd, st2_rd, nf_set, nf_clr;
  logic [7:0] byte_sel;

  always_comb begin
    st1_rd = reg_hit(reg_req_i, `SFIC_OFF_STATUS1, 1'b0);
    st2_rd = reg_hit(reg_req_i, `SFIC_OFF_STATUS2, 1'b0);
    // Sampled one cycle after the push so the new count is visible
    nf_set = nearfull_assert_style ? (near_cond && !cond_q)
                                   : (near_cond && pushed_q);
    nf_clr = st1_rd || (nearfull_clear_on_data_read && data_rd);
    // Set beats clear so an event in the clearing cycle survives
    next_nearfull_flag      = nf_set || (nearfull_flag && !nf_clr);
    next_supply_range_flag  = supply_out_of_range_i || (supply_range_flag && !st2_rd);
    next_cardiac_ready_flag = cardiac_done_i || (cardiac_ready_flag && !st2_rd);
    next_irq_n = !((nearfull_flag && nearfull_irq_enable) ||
                   (supply_range_flag && supply_range_irq_enable) ||
                   (cardiac_ready_flag && cardiac_ready_irq_enable));

    unique case (part_sel)
      2'd0:    byte_sel = mem[rd_ptr].elem[elem_sel][23:16];
      2'd1:    byte_sel = mem[rd_ptr].elem[elem_sel][15:8];
      default: byte_sel = mem[rd_ptr].elem[elem_sel][7:0];
    endcase

    next_rdata = rdata;
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        `SFIC_OFF_STATUS1: next_rdata = {nearfull_flag, 7'h00};
        `SFIC_OFF_STATUS2: next_rdata = {supply_range_flag, 4'h0, cardiac_ready_flag, 2'h0};
        `SFIC_OFF_IRQEN1:  next_rdata = {nearfull_irq_enable, 7'h00};
        `SFIC_OFF_IRQEN2:  next_rdata = {supply_range_irq_enable, 4'h0, cardiac_ready_irq_enable, 2'h0};
        `SFIC_OFF_WRPTR:   next_rdata = {3'h0, wr_ptr};
        `SFIC_OFF_LOST:    next_rdata = {3'h0, lost};
        `SFIC_OFF_RDPTR:   next_rdata = {3'h0, rd_ptr};
        `SFIC_OFF_DATA:    next_rdata = empty ? 8'h00 : byte_sel;
        `SFIC_OFF_CFG:     next_rdata = {1'b0, nearfull_clear_on_data_read, nearfull_assert_style,
                                         overwrite_when_full, nearfull_free_slots};
        `SFIC_OFF_SLOT12:  next_rdata = {slot_type[1], slot_type[0]};
        `SFIC_OFF_SLOT34:  next_rdata = {slot_type[3], slot_type[2]};
        `SFIC_OFF_SYSCTL:  next_rdata = {5'h00, sample_store_enable, 2'h0};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      nearfull_flag      <= 1'b0;
      supply_range_flag  <= 1'b0;
      cardiac_ready_flag <= 1'b0;
      cond_q             <= 1'b0;
      rdata              <= 8'h00;
      irq_n              <= 1'b1;
      active             <= 4'h0;
    end else begin
      nearfull_flag      <= next_nearfull_flag;
      supply_range_flag  <= next_supply_range_flag;
      cardiac_ready_flag <= next_cardiac_ready_flag;
      cond_q             <= near_cond;
      rdata              <= next_rdata;
      irq_n              <= next_irq_n;
      active             <= next_active;
    end
  end

  assign reg_rdata_o    = rdata;
  assign irq_n_o        = irq_n;
  assign active_slots_o = active;

endmodule : sfic_top

`default_nettype wire

// ### verilog/sfic_regs.svh
`ifndef SFIC_REGS_SVH
`define SFIC_REGS_SVH

// ==========================================================
// Register offsets
`define SFIC_OFF_STATUS1   8'h00
`define SFIC_OFF_STATUS2   8'h01
`define SFIC_OFF_IRQEN1    8'h02
`define SFIC_OFF_IRQEN2    8'h03
`define SFIC_OFF_WRPTR     8'h04
`define SFIC_OFF_LOST      8'h05
`define SFIC_OFF_RDPTR     8'h06
`define SFIC_OFF_DATA      8'h07
`define SFIC_OFF_CFG       8'h08
`define SFIC_OFF_SLOT12    8'h09
`define SFIC_OFF_SLOT34    8'h0A
`define SFIC_OFF_SYSCTL    8'h0D

// ==========================================================
// Field positions
`define SFIC_BIT_NEARFULL  7
`define SFIC_BIT_SUPPLY    7
`define SFIC_BIT_CARDIAC   2
`define SFIC_BIT_CFG_CLR   6
`define SFIC_BIT_CFG_STYLE 5
`define SFIC_BIT_CFG_ROLL  4
`define SFIC_BIT_STORE_EN  2

// ==========================================================
// Reset values and limits
`define SFIC_RST_FREE      4'hF
`define SFIC_RST_PTR       5'h00
`define SFIC_RST_SLOT      4'h0
`define SFIC_LOST_MAX      5'h1F
`define SFIC_LAST_PART     2'h2

// ==========================================================
// Slot type codes
`define SFIC_CODE_NONE     4'h0
`define SFIC_CODE_OPT1     4'h1
`define SFIC_CODE_OPT2     4'h2
`define SFIC_CODE_PILOT1   4'h5
`define SFIC_CODE_PILOT2   4'h6
`define SFIC_CODE_CARDIAC  4'h9

`endif

// ### verilog/sfic_pkg.sv
package sfic_pkg;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfic_reg_req_t;

  typedef struct packed {
    logic [3:0][23:0] elem;
  } sfic_sample_t;

  typedef enum logic [2:0] {
    SFIC_KIND_NONE,
    SFIC_KIND_OPT1,
    SFIC_KIND_OPT2,
    SFIC_KIND_PILOT1,
    SFIC_KIND_PILOT2,
    SFIC_KIND_CARDIAC,
    SFIC_KIND_RESERVED
  } sfic_kind_t;

endpackage : sfic_pkg

// ### verilog/sfic_stage_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module sfic_stage_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sfic_stage_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx, next_wr_idx, rd_idx, next_rd_idx;
  logic [AW:0]      count, next_count;
  logic             full, next_full, empty, next_empty;
  logic             room;
  logic             push, pop;

  // ==========================================================
  // Next state
  always_comb begin
    push        = in_valid_i && !full;
    pop         = out_ready_i && !empty;
    next_wr_idx = push ? wr_idx + 1'b1 : wr_idx;
    next_rd_idx = pop ? rd_idx + 1'b1 : rd_idx;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    // Flags are registered so ready leaves on a flip-flop; valid is the inverted empty flop
    next_full   = next_count == (AW+1)'(DEPTH);
    next_empty  = next_count == '0;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
      full   <= 1'b0;
      room   <= 1'b1;
      empty  <= 1'b1;
    end else begin
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      count  <= next_count;
      full   <= next_full;
      room   <= !next_full;
      empty  <= next_empty;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  // Own flop so the ready output carries no gate after the register
  assign in_ready_o  = room;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rd_idx];

endmodule : sfic_stage_fifo

`default_nettype wire

// ### dv/sfic_src.sv
`timescale 1ns/1ns
`default_nettype none
module sfic_src (
  // Clock
  input wire logic               mclk_i,
  // Sample stream to the block
  input wire logic               ready_i,
  output var sfic_pkg::sfic_sample_t sample_o,
  output logic                   valid_o
);
  // ==========================================================
  // Front end source
  logic stuck;
  initial begin
    valid_o = 1'b0;
    sample_o = '0;
    stuck = 1'b0;
  end
  // One whole word per handshake; idle data inverted so stale values never match
  task automatic push(input logic [7:0] k);
    int n;
    n = 0;
    @(negedge mclk_i);
    sample_o = '0;
    sample_o.elem[0] = {16'hA000, k};
    sample_o.elem[1] = {16'hB000, k};
    valid_o = 1'b1;
    while (ready_i !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 100) begin
      stuck = 1'b1;
    end
    @(negedge mclk_i);
    valid_o = 1'b0;
    sample_o = ~sample_o;
  endtask : push
endmodule : sfic_src
`default_nettype wire

// ### dv/sfic_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfic_regs.svh"
module sfic_top_chk (
  // Clock and reset
  input wire logic                    mclk_i,
  input wire logic                    rst_i,
  // Watched ports
  input wire sfic_pkg::sfic_reg_req_t reg_req_i,
  input wire logic [7:0]              reg_rdata_o,
  input wire logic                    supply_out_of_range_i,
  input wire logic                    cardiac_done_i,
  input wire logic                    irq_n_o,
  input wire logic [3:0]              active_slots_o
);
  // ==========================================================
  // Mirror of host writes
  logic [7:0] en1, en2, s12, s34, next_en1, next_en2, next_s12, next_s34;
  logic       quiet, req_any, wsl;
  function automatic logic ok(input logic [3:0] c);
    return c inside {4'h1, 4'h2, 4'h5, 4'h6, 4'h9};
  endfunction : ok
  assign quiet = !(en1[7] || en2[7] || en2[2]);
  assign req_any = reg_req_i.rd || reg_req_i.wr;
  assign wsl = reg_req_i.wr && reg_req_i.addr inside {`SFIC_OFF_SLOT12, `SFIC_OFF_SLOT34};
  always_comb begin
    {next_en1, next_en2, next_s12, next_s34} = {en1, en2, s12, s34};
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        `SFIC_OFF_IRQEN1: next_en1 = reg_req_i.wdata;
        `SFIC_OFF_IRQEN2: next_en2 = reg_req_i.wdata;
        `SFIC_OFF_SLOT12: next_s12 = reg_req_i.wdata;
        `SFIC_OFF_SLOT34: next_s34 = reg_req_i.wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      {en1, en2, s12, s34} <= '0;
    end else begin
      {en1, en2, s12, s34} <= {next_en1, next_en2, next_s12, next_s34};
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_supply_gate: assert property (supply_out_of_range_i && en2[7] |-> ##[1:3] !irq_n_o)
    else $error("supply event did not raise irq");
  a_cardiac_gate: assert property (cardiac_done_i && en2[2] |-> ##[1:3] !irq_n_o)
    else $error("cardiac event did not raise irq");
  a_irq_quiet: assert property (quiet && $past(quiet) |-> irq_n_o)
    else $error("irq active with all enables off");
  a_irq_holds: assert property (!irq_n_o && !req_any && !$past(req_any) |=> !irq_n_o)
    else $error("irq released with no clearing access");
  a_slot_decode: assert property (!$past(wsl) |->
    active_slots_o == {ok(s34[7:4]), ok(s34[3:0]), ok(s12[7:4]), ok(s12[3:0])})
    else $error("active slots disagree with slot types");
  a_slot_readback: assert property (reg_req_i.rd && reg_req_i.addr == `SFIC_OFF_SLOT12
    |=> reg_rdata_o == $past(s12))
    else $error("slot register read back wrong");
  a_rdata_hold: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_ptr_width: assert property (reg_req_i.rd && reg_req_i.addr inside {`SFIC_OFF_WRPTR, `SFIC_OFF_LOST,
    `SFIC_OFF_RDPTR} |=> reg_rdata_o[7:5] == 3'h0)
    else $error("pointer or counter wider than five bits");
endmodule : sfic_top_chk
bind sfic_top sfic_top_chk sfic_top_chk_i (.mclk_i, .rst_i, .reg_req_i, .reg_rdata_o, .supply_out_of_range_i,
  .cardiac_done_i, .irq_n_o, .active_slots_o);
`default_nettype wire

// ### dv/sfic_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sfic_top_tb;
  // ==========================================================
  // Bench signals
  logic                    mclk_i, rst_i, sv, sr, sup, card, prox, irq_n;
  sfic_pkg::sfic_reg_req_t req;
  sfic_pkg::sfic_sample_t  smp;
  logic [7:0]              rdata, k;
  logic [3:0]              act;
  logic [7:0]              eb [6] = '{8'hA0, 8'h00, 8'h00, 8'hB0, 8'h00, 8'h00};
  int                      miscompares, num_checks;
  sfic_top sfic_top_i (.mclk_i, .rst_i, .reg_req_i(req), .reg_rdata_o(rdata), .sample_i(smp),
    .sample_valid_i(sv), .sample_ready_o(sr), .supply_out_of_range_i(sup), .cardiac_done_i(card),
    .proximity_mode_i(prox), .irq_n_o(irq_n), .active_slots_o(act));
  sfic_src sfic_src_i (.mclk_i, .ready_i(sr), .sample_o(smp), .valid_o(sv));
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : ck
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req = {1'b0, 1'b1, a, d};
    @(negedge mclk_i);
    req = '0;
  endtask : w
  task automatic rr(input logic [7:0] a);
    @(negedge mclk_i);
    req = {1'b1, 1'b0, a, 8'h00};
    @(negedge mclk_i);
    req = '0;
  endtask : rr
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    rr(a);
    ck(rdata, e);
  endtask : r
  // Drain timing is not fixed, so poll with a bound
  task automatic poll(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      rr(a);
      n++;
    end while (rdata !== e && n < 40);
    ck(rdata, e);
  endtask : poll
  task automatic p(input int n);
    repeat (n) begin
      sfic_src_i.push(k);
      k++;
    end
  endtask : p
  task automatic ckirq(input logic e);
    repeat (6) @(negedge mclk_i);
    ck({7'h0, irq_n}, {7'h0, e});
  endtask : ckirq
  task automatic pulse();
    @(negedge mclk_i);
    card = 1'b1;
    @(negedge mclk_i);
    card = 1'b0;
  endtask : pulse
  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {rst_i, req, sup, card, prox, k, miscompares, num_checks} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    r(8'h08, 8'h0F);
    r(8'h04, 8'h00);
    r(8'h05, 8'h00);
    r(8'h06, 8'h00);
    r(8'h09, 8'h00);
    for (int c = 0; c < 16; c++) begin
      w(8'h09, c[7:0]);
      @(negedge mclk_i);
      ck({7'h0, act[0]}, {7'h0, c inside {1, 2, 5, 6, 9}});
    end
    w(8'h09, 8'h21);
    r(8'h09, 8'h21);
    w(8'h0A, 8'h90);
    @(negedge mclk_i);
    ck({4'h0, act}, 8'h0B);
    w(8'h0A, 8'h00);
    p(16);
    ck({7'h0, sr}, 8'h00);
    r(8'h04, 8'h00);
    w(8'h0D, 8'h04);
    poll(8'h04, 8'h10);
    for (int i = 0; i < 6; i++) r(8'h07, eb[i]);
    r(8'h06, 8'h01);
    w(8'h06, 8'h00);
    r(8'h07, 8'hA0);
    w(8'h06, 8'h00);
    r(8'h00, 8'h00);
    p(1);
    ckirq(1'b1);
    w(8'h02, 8'h80);
    ckirq(1'b0);
    r(8'h00, 8'h80);
    ckirq(1'b1);
    p(1);
    ckirq(1'b0);
    r(8'h00, 8'h80);
    w(8'h08, 8'h2F);
    p(1);
    ckirq(1'b1);
    r(8'h00, 8'h00);
    w(8'h08, 8'h20);
    w(8'h08, 8'h2F);
    r(8'h00, 8'h80);
    w(8'h08, 8'h4F);
    p(1);
    ckirq(1'b0);
    rr(8'h07);
    ckirq(1'b1);
    w(8'h02, 8'h00);
    w(8'h08, 8'h0F);
    p(14);
    r(8'h04, 8'h00);
    r(8'h05, 8'h02);
    w(8'h05, 8'h11);
    r(8'h05, 8'h02);
    w(8'h08, 8'h1F);
    p(1);
    r(8'h04, 8'h01);
    r(8'h06, 8'h01);
    w(8'h08, 8'h0F);
    prox = 1'b1;
    p(1);
    r(8'h04, 8'h02);
    r(8'h06, 8'h02);
    p(30);
    r(8'h05, 8'h1F);
    prox = 1'b0;
    w(8'h0D, 8'h00);
    p(1);
    r(8'h04, 8'h00);
    w(8'h0D, 8'h04);
    poll(8'h04, 8'h01);
    r(8'h05, 8'h00);
    w(8'h03, 8'h80);
    sup = 1'b1;
    ckirq(1'b0);
    sup = 1'b0;
    r(8'h01, 8'h80);
    ckirq(1'b1);
    w(8'h03, 8'h00);
    pulse();
    ckirq(1'b1);
    r(8'h01, 8'h04);
    w(8'h03, 8'h04);
    pulse();
    ckirq(1'b0);
    r(8'h03, 8'h04);
    r(8'h01, 8'h04);
    ckirq(1'b1);
    ck({7'h0, sfic_src_i.stuck}, 8'h00);
    test_done();
  end
endmodule : sfic_top_tb
`default_nettype wire
